// ---- hdl/acms_consts.vh ----
`ifndef ACMS_CONSTS_VH
`define ACMS_CONSTS_VH

// cycle states
`define ACMS_ST_CONV 2'b00
`define ACMS_ST_SLEEP 2'b01
`define ACMS_ST_OUT 2'b10

// serial frame layout
`define ACMS_FRAME_BITS 32
`define ACMS_CFG_BITS 8
`define ACMS_CFG_EN 7
`define ACMS_CFG_TEMP 3
`define ACMS_CFG_REJ_HI 2
`define ACMS_CFG_REJ_LO 1
`define ACMS_CFG_SPEED 0

// rejection encodings
`define ACMS_REJ_BOTH 2'b00
`define ACMS_REJ_50 2'b01
`define ACMS_REJ_60 2'b10
`define ACMS_REJ_RSVD 2'b11

// reset mode word: temp, rej[1:0], speed
`define ACMS_MODE_RESET 4'h0

// conversion timing, in clk cycles per internal half conversion
`define ACMS_HALF_CONV_CYCLES 16'h0400

`endif

// ---- hdl/acms_sync.v ----
`timescale 1ns/1ps
// two flop synchroniser for pin inputs
module acms_sync
(
    input wire clk,
    input wire nrst,
    input wire en,
    input wire rst_val,
    input wire d,
    output wire q
);
    reg s1_q;
    reg s2_q;

    // ***************************************
    // synchroniser chain
    // ***************************************
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end
        else if (en)
        begin
            s1_q <= d ^ rst_val;
            s2_q <= s1_q;
        end
    end

    assign q = s2_q ^ rst_val;
endmodule // acms_sync

// ---- hdl/acms_result_mem.v ----
`timescale 1ns/1ps
// static result holding register, registered read
module acms_result_mem
(
    input wire clk,
    input wire nrst,
    input wire en,
    input wire wr,
    input wire [31:0] wdata,
    output reg [31:0] rdata
);
    reg [31:0] mem_q;

    // ***************************************
    // store and read back
    // ***************************************
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mem_q <= 32'h00000000;
            rdata <= 32'h00000000;
        end
        else if (en)
        begin
            if (wr)
                mem_q <= wdata;
            rdata <= mem_q;
        end
    end
endmodule // acms_result_mem

// ---- hdl/acms_ctrl.v ----
`timescale 1ns/1ps
`include "acms_consts.vh"
// Behaviour
// - cycle repeats conversion, sleep, data output in fixed order
// - after conversion sleep, stay while select high
// - sleeping keeps the finished result held indefinitely
// - select low during sleep enters data output state
// - select high before first serial rising edge returns to sleep
// - after first rising edge, select high aborts and starts conversion
// - result bits advance on serial clock falling edge
// - serial input captured on serial clock rising edge
// - serial input held low keeps the previous mode; external input, dual rejection after power-up
// - modes follow only select and clock timing, cycle unchanged
// - one configuration word shifts in during the output cycle
// - power-up mode external, dual rejection, normal speed
// - word starts with enable; enable zero keeps previous mode
// - first three data bits after enable ignored
// - fourth data bit selects temperature sensor input
// - fifth and sixth bits pick rejection; 11 reserved
// - seventh bit doubles rate by dropping offset calibration
// - temperature input forces normal speed
// - normal speed does two conversions and combines them
// - each result settles within one conversion cycle
// - in conversion and sleep, output shows busy high, done low
// - frame is 32 bits: status, 24-bit result, five sub bits
// - clock mode from clock pin at reset or select fall; reset strap takes synchroniser reset value 0, not the pin
module acms_ctrl
(
    input wire clk,
    input wire nrst,
    input wire clk_en,
    input wire sel_n,
    input wire sclk_in,
    input wire serial_in,
    input wire [28:0] conv_data,
    output reg serial_out,
    output reg serial_out_oe_n,
    output reg ext_sclk_mode,
    output reg converting,
    output reg temp_input_sel,
    output reg reject_sel_hi,
    output reg reject_sel_lo,
    output reg double_rate_sel,
    output reg [1:0] state
);
    wire sel_n_s;
    wire sclk_s;
    wire sdi_s;
    wire [31:0] held_frame;
    reg sel_n_d1_q;
    reg sclk_d1_q;
    reg first_rise_q;
    reg [5:0] bit_cnt_q;
    reg [7:0] cfg_sr_q;
    reg [3:0] cfg_cnt_q;
    reg [3:0] pend_mode_q;
    reg [3:0] act_mode_q;
    reg [31:0] out_sr_q;
    reg [15:0] conv_cnt_q;
    reg phase_q;
    reg [28:0] acc_q;
    reg store_q;
    reg store_d1_q;
    reg strap_q;
    wire sel_fall;
    wire sel_rise;
    wire sck_rise;
    wire sck_fall;

    // frame assembly: done flag, dummy, pad bit, 29 data bits
    function [31:0] mk_frame;
        input [28:0] d;
        begin
            mk_frame = {1'b0, 1'b0, 1'b0, d};
        end
    endfunction

    // mean of two halves, carry kept so equal halves lose no bit
    function [28:0] avg2;
        input [28:0] a;
        input [28:0] b;
        reg [29:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            avg2 = s[29:1];
        end
    endfunction

    // ***************************************
    // pin synchronisers
    // ***************************************
    acms_sync u_sel
    (
        .clk(clk),
        .nrst(nrst),
        .en(clk_en),
        .rst_val(1'b1),
        .d(sel_n),
        .q(sel_n_s)
    );
    acms_sync u_sck
    (
        .clk(clk),
        .nrst(nrst),
        .en(clk_en),
        .rst_val(1'b0),
        .d(sclk_in),
        .q(sclk_s)
    );
    acms_sync u_sdi
    (
        .clk(clk),
        .nrst(nrst),
        .en(clk_en),
        .rst_val(1'b0),
        .d(serial_in),
        .q(sdi_s)
    );

    acms_result_mem u_mem
    (
        .clk(clk),
        .nrst(nrst),
        .en(clk_en),
        .wr(store_q),
        .wdata(mk_frame(acc_q)),
        .rdata(held_frame)
    );

    // edge detect on synchronised copies
    assign sel_fall = sel_n_d1_q & ~sel_n_s;
    assign sel_rise = ~sel_n_d1_q & sel_n_s;
    assign sck_rise = ~sclk_d1_q & sclk_s;
    assign sck_fall = sclk_d1_q & ~sclk_s;

    // ***************************************
    // edge history and clock strap
    // ***************************************
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sel_n_d1_q <= 1'b1;
            sclk_d1_q <= 1'b0;
            strap_q <= 1'b0;
            ext_sclk_mode <= 1'b0;
        end
        else if (clk_en)
        begin
            sel_n_d1_q <= sel_n_s;
            sclk_d1_q <= sclk_s;
            if (!strap_q)
            begin
                strap_q <= 1'b1;
                ext_sclk_mode <= sclk_s;
            end
            else if (sel_fall)
                ext_sclk_mode <= sclk_s;
        end
    end

    // ***************************************
    // cycle state machine
    // ***************************************
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= `ACMS_ST_CONV;
            conv_cnt_q <= 16'h0000;
            phase_q <= 1'b0;
            acc_q <= 29'h00000000;
            store_q <= 1'b0;
            store_d1_q <= 1'b0;
            first_rise_q <= 1'b0;
            bit_cnt_q <= 6'h00;
            out_sr_q <= 32'h00000000;
            cfg_sr_q <= 8'h00;
            cfg_cnt_q <= 4'h0;
            pend_mode_q <= `ACMS_MODE_RESET;
            act_mode_q <= `ACMS_MODE_RESET;
        end
        else if (clk_en)
        begin
            store_q <= 1'b0;
            store_d1_q <= store_q;
            case (state)
            `ACMS_ST_CONV:
            begin
                // two halves in normal speed, one in double rate
                if (conv_cnt_q == `ACMS_HALF_CONV_CYCLES - 16'h0001)
                begin
                    conv_cnt_q <= 16'h0000;
                    if (!phase_q && !act_mode_q[0])
                    begin
                        phase_q <= 1'b1;
                        acc_q <= conv_data;
                    end
                    else
                    begin
                        phase_q <= 1'b0;
                        // combine halves; result from this cycle only
                        acc_q <= act_mode_q[0] ? conv_data :
                            avg2(acc_q, conv_data);
                        store_q <= 1'b1;
                        state <= `ACMS_ST_SLEEP;
                    end
                end
                else
                    conv_cnt_q <= conv_cnt_q + 16'h0001;
            end
            `ACMS_ST_SLEEP:
            begin
                // result held in memory while select high
                // wait until the read register holds the new frame
                if (!sel_n_s && !store_q && !store_d1_q)
                begin
                    state <= `ACMS_ST_OUT;
                    first_rise_q <= 1'b0;
                    bit_cnt_q <= 6'h00;
                    cfg_cnt_q <= 4'h0;
                    out_sr_q <= held_frame;
                end
            end
            `ACMS_ST_OUT:
            begin
                if (sel_rise)
                begin
                    if (first_rise_q)
                    begin
                        state <= `ACMS_ST_CONV;
                        act_mode_q <= pend_mode_q;
                    end
                    else
                        state <= `ACMS_ST_SLEEP;
                end
                else
                begin
                    if (sck_rise)
                    begin
                        first_rise_q <= 1'b1;
                        if (cfg_cnt_q != 4'h8)
                        begin
                            cfg_sr_q <= {cfg_sr_q[6:0], sdi_s};
                            cfg_cnt_q <= cfg_cnt_q + 4'h1;
                        end
                        if (cfg_cnt_q == 4'h7 &&
                            cfg_sr_q[6] == 1'b1)
                        begin
                            // bits 6..4 of word ignored
                            pend_mode_q[3] <= cfg_sr_q[2];
                            pend_mode_q[2] <= cfg_sr_q[1];
                            pend_mode_q[1] <= cfg_sr_q[0];
                            pend_mode_q[0] <= sdi_s & ~cfg_sr_q[2];
                        end
                    end
                    if (sck_fall && first_rise_q)
                    begin
                        out_sr_q <= {out_sr_q[30:0], 1'b1};
                        bit_cnt_q <= bit_cnt_q + 6'h01;
                        if (bit_cnt_q == `ACMS_FRAME_BITS - 1)
                        begin
                            state <= `ACMS_ST_CONV;
                            act_mode_q <= pend_mode_q;
                        end
                    end
                end
            end
            default:
                state <= `ACMS_ST_CONV;
            endcase
        end
    end

    // ***************************************
    // pin and mode outputs
    // ***************************************
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            serial_out <= 1'b1;
            serial_out_oe_n <= 1'b1;
            converting <= 1'b1;
            temp_input_sel <= 1'b0;
            reject_sel_hi <= 1'b0;
            reject_sel_lo <= 1'b0;
            double_rate_sel <= 1'b0;
        end
        else if (clk_en)
        begin
            serial_out_oe_n <= sel_n_s;
            converting <= (state == `ACMS_ST_CONV);
            if (state == `ACMS_ST_OUT && first_rise_q)
                serial_out <= out_sr_q[31];
            else if (state == `ACMS_ST_OUT)
                serial_out <= 1'b0;
            else
                serial_out <= (state == `ACMS_ST_CONV);
            temp_input_sel <= act_mode_q[3];
            reject_sel_hi <= act_mode_q[2];
            reject_sel_lo <= act_mode_q[1];
            double_rate_sel <= act_mode_q[0];
        end
    end
    // no register programs the clocking modes
    // reserved rejection code is passed on unchecked
endmodule // acms_ctrl

// ---- tb/acms_monitor.sv ----
`timescale 1ns/1ps
`include "acms_consts.vh"
// ****************************************
// checker on the control block ports
// ****************************************
module acms_monitor
(
    input wire clk,
    input wire nrst,
    input wire sel_n,
    input wire serial_out,
    input wire serial_out_oe_n,
    input wire temp_input_sel,
    input wire reject_sel_hi,
    input wire reject_sel_lo,
    input wire double_rate_sel,
    input wire [1:0] state
);
    localparam [15:0] HALF = `ACMS_HALF_CONV_CYCLES;
    logic [15:0] cnt_q;
    wire [15:0] conv_len = double_rate_sel ? HALF : (HALF << 1);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // length of the current conversion
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt_q <= 16'h0000;
        else if (state == 2'b00)
            cnt_q <= cnt_q + 16'h0001;
        else
            cnt_q <= 16'h0000;
    end
    a_cycle_order: assert property (
        $changed(state) |-> ($past(state) == 2'b00 && state == 2'b01) ||
        ($past(state) == 2'b01 && state == 2'b10) || $past(state) == 2'b10)
        else $error("bad state order");
    a_sleep_held: assert property (
        (state == 2'b01 && sel_n && $past(sel_n) && $past(sel_n, 2)
        && $past(sel_n, 3)) |=> state == 2'b01) else $error("left sleep");
    a_wake_out: assert property (
        (state == 2'b01 && $fell(sel_n)) ##1 (!sel_n)[*3]
        |-> ##[0:2] state == 2'b10) else $error("no wake");
    a_abort_out: assert property (
        (state == 2'b10 && $rose(sel_n)) ##1 sel_n[*3]
        |-> ##[0:2] state != 2'b10) else $error("no abort");
    a_busy_high: assert property (
        state == 2'b00 && $past(state) == 2'b00 && !serial_out_oe_n
        |-> serial_out) else $error("busy not shown");
    a_eoc_low: assert property (
        $rose(state == 2'b10) |-> ##1 !serial_out) else $error("eoc high");
    a_oe_idle: assert property (
        sel_n[*4] |-> serial_out_oe_n) else $error("driven while idle");
    a_conv_len: assert property (
        $past(state) == 2'b00 && state == 2'b01 |->
        $past(cnt_q) + 16'h0002 >= conv_len &&
        $past(cnt_q) <= conv_len + 16'h0002) else $error("bad conv time");
    a_mode_hold: assert property (
        $changed({temp_input_sel, reject_sel_hi, reject_sel_lo,
        double_rate_sel}) |-> $past(state) == 2'b10 ||
        $past(state, 2) == 2'b10) else $error("mode moved");
    a_temp_slow: assert property (
        temp_input_sel |-> !double_rate_sel) else $error("temp fast");
endmodule // acms_monitor

bind acms_ctrl acms_monitor u_mon
(
    .clk(clk), .nrst(nrst), .sel_n(sel_n), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .temp_input_sel(temp_input_sel),
    .reject_sel_hi(reject_sel_hi), .reject_sel_lo(reject_sel_lo),
    .double_rate_sel(double_rate_sel), .state(state)
);

// ---- tb/acms_host_model.sv ----
`timescale 1ns/1ps
// ****************************************
// host side of the serial link
// ****************************************
module acms_host_model
(
    output logic sel_n,
    output logic sclk,
    output logic serial_in,
    input wire serial_out,
    input wire serial_out_oe_n,
    output logic [31:0] rx_frame,
    output int rx_cnt
);
    // released line shows the inverse of the last value
    wire line = serial_out_oe_n ? ~serial_out : serial_out;
    // idle levels, clock stands low between frames
    initial
    begin
        sel_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
        rx_frame = 32'h00000000;
        rx_cnt = 0;
    end
    // one select window with nclk clocks of 400 ns
    task automatic xfer(input logic [7:0] cfg, input int nclk);
        int k;
        sel_n = 1'b0;
        serial_in = cfg[7];
        #400;
        for (k = 0; k < nclk; k++)
        begin
            sclk = 1'b1;
            #200;
            rx_frame[31 - k] = line;
            sclk = 1'b0;
            serial_in = (k < 7) ? cfg[6 - k] : ~serial_in;
            #200;
        end
        sel_n = 1'b1;
        serial_in = ~serial_in;
        if (nclk == 32)
            rx_cnt++;
    endtask
endmodule // acms_host_model

// ---- tb/test_adc_cycle_and_mode_serial.sv ----
`timescale 1ns/1ps
module test_adc_cycle_and_mode_serial;
    logic clk, nrst, sel_n, sclk, serial_in;
    logic [28:0] conv_data, held;
    logic [31:0] rx_frame;
    int rx_cnt, fail_count, num_checks;
    wire serial_out, oe_n, temp, rhi, rlo, dbl, ext, conv;
    wire [1:0] state;
    logic [35:0] exp_q[$];
    logic [3:0] mode;
    logic [7:0] cfgs[6] = '{8'hF2, 8'h84, 8'h81, 8'h0F, 8'h89, 8'h80};
    acms_ctrl dut
    (
        .clk(clk), .nrst(nrst), .clk_en(1'b1), .sel_n(sel_n),
        .sclk_in(sclk), .serial_in(serial_in), .conv_data(conv_data),
        .serial_out(serial_out), .serial_out_oe_n(oe_n),
        .ext_sclk_mode(ext), .converting(conv), .temp_input_sel(temp),
        .reject_sel_hi(rhi), .reject_sel_lo(rlo),
        .double_rate_sel(dbl), .state(state)
    );
    acms_host_model host
    (
        .sel_n(sel_n), .sclk(sclk), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_oe_n(oe_n),
        .rx_frame(rx_frame), .rx_cnt(rx_cnt)
    );
    // system clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // wait for sleep under a bound
    task automatic wait_sleep;
        int n;
        @(negedge clk);
        for (n = 0; n < 4000 && state !== 2'b01; n++)
            @(negedge clk);
        check({34'h0, state}, 36'h1);
    endtask
    // full frame: note result and mode, load next sample
    task automatic frame(input logic [7:0] cfg);
        wait_sleep;
        if (cfg[7])
            mode = {cfg[3], cfg[2:1], cfg[0] & ~cfg[3]};
        exp_q.push_back({mode, 3'b000, held});
        conv_data = 29'($urandom);
        held = conv_data;
        host.xfer(cfg, 32);
    endtask
    // compare each finished frame and the mode left behind
    initial
    forever
    begin
        @(rx_cnt);
        repeat (8) @(negedge clk);
        check({temp, rhi, rlo, dbl, rx_frame}, exp_q.pop_front());
    end
    // main sequence
    initial
    begin
        fail_count = 0;
        num_checks = 0;
        mode = 4'h0;
        nrst = 1'b0;
        void'($urandom(32'h8850EFC0));
        conv_data = 29'($urandom);
        held = conv_data;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        check({32'h0, temp, rhi, rlo, dbl}, 36'h0);
        host.xfer(8'h80, 0);
        foreach (cfgs[i])
            frame(cfgs[i]);
        wait_sleep;
        conv_data = ~held;
        host.xfer(8'hFF, 0);
        repeat (10) @(negedge clk);
        check({34'h0, state}, 36'h1);
        frame(8'h00);
        wait_sleep;
        host.xfer(8'h89, 5);
        repeat (10) @(negedge clk);
        check({34'h0, state}, 36'h0);
        check({35'h0, conv}, 36'h1);
        check({35'h0, ext}, 36'h0);
        frame(8'h00);
        repeat (20) @(negedge clk);
        report_and_stop;
    end
    // watchdog against a hang
    initial
    begin
        repeat (60000) @(negedge clk);
        fail_count++;
        report_and_stop;
    end
endmodule // test_adc_cycle_and_mode_serial
